// [inc/e1_status_pkg.sv]
// ==========================================================================
// register map and field layout
// ==========================================================================
package e1_status_pkg;
   localparam int NUM_PORTS = 4;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 8;
   localparam int CNT_W = 6;

   localparam logic [4:0] ADDR_RX_INFO = 5'h08;
   localparam logic [4:0] ADDR_SYNC_STATE = 5'h09;
   localparam logic [4:0] ADDR_STATUS_ONE = 5'h0A;
   localparam logic [4:0] ADDR_STATUS_TWO = 5'h0B;
   localparam logic [4:0] ADDR_SUMMARY_LO = 5'h0C;
   localparam logic [4:0] ADDR_SUMMARY_HI = 5'h0E;
   localparam logic [4:0] ADDR_MASK_ONE = 5'h18;
   localparam logic [4:0] ADDR_MASK_TWO = 5'h19;

   // latched register slots
   localparam logic [1:0] SLOT_ONE = 2'h0;
   localparam logic [1:0] SLOT_TWO = 2'h1;
   localparam logic [1:0] SLOT_INFO = 2'h2;
   localparam logic [1:0] SLOT_NONE = 2'h3;

   // status_reg_one: bits 3..0 alarms, 7..5 once-only, 4 slip
   localparam logic [7:0] ALARM_MASK_ONE = 8'h0F;
   localparam logic [7:0] ONCE_MASK_ONE = 8'hE0;
   // status_reg_two: tx_clock_loss bit 2, prbs_detect bit 0
   localparam logic [7:0] ONCE_MASK_TWO = 8'h05;
   localparam logic [7:0] INFO_USED = 8'h3F;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [5:0] CNT_RESET = 6'h00;
   localparam logic [5:0] CNT_ONE = 6'h01;
endpackage : e1_status_pkg

// [rtl/crc4_sync_counter.sv]
`timescale 1ns/1ps
module crc4_sync_counter
   import e1_status_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // synchronizer events
   input wire logic search_timeout,
   input wire logic crc4_synced,
   input wire logic crc4_mode_en,
   // count
   output logic [CNT_W-1:0] count_q
);
   logic [CNT_W-1:0] count_d;

   // ========================================================================
   // counter
   // ========================================================================
   always_comb
   begin
      count_d = count_q;
      if (crc4_synced || !crc4_mode_en)
      begin
         count_d = CNT_RESET;
      end
      else if (search_timeout)
      begin
         count_d = CNT_W'(count_q + CNT_ONE);
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         count_q <= CNT_RESET;
      end
      else
      begin
         count_q <= count_d;
      end
   end

   // ========================================================================
   // checks
   // ========================================================================
   AST_CNT_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n)
      (crc4_synced || !crc4_mode_en) |=> count_q == CNT_RESET)
      else $error("sync counter not cleared");
   AST_CNT_STEP: assert property (@(posedge core_clk) disable iff (!rst_n)
      (search_timeout && crc4_mode_en && !crc4_synced)
      |=> count_q == CNT_W'($past(count_q) + CNT_ONE))
      else $error("sync counter did not step or wrap");
endmodule : crc4_sync_counter

// [rtl/e1_status_interrupt_logic.sv]
`timescale 1ns/1ps
module e1_status_interrupt_logic
   import e1_status_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [1:0] reg_port,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [DATA_W-1:0] reg_wdata,
   output logic [DATA_W-1:0] reg_rdata_q,
   output logic reg_rvalid_q,
   // status_reg_one sources
   input wire logic [NUM_PORTS-1:0] rx_sig_all_ones,
   input wire logic [NUM_PORTS-1:0] rx_distant_mf_alarm,
   input wire logic [NUM_PORTS-1:0] rx_sig_all_zeros,
   input wire logic [NUM_PORTS-1:0] slip,
   input wire logic [NUM_PORTS-1:0] rx_unframed_ones,
   input wire logic [NUM_PORTS-1:0] rx_remote_alarm,
   input wire logic [NUM_PORTS-1:0] rx_carrier_loss,
   input wire logic [NUM_PORTS-1:0] rx_sync_loss,
   // status_reg_two sources
   input wire logic [NUM_PORTS-1:0] rx_cas_multiframe,
   input wire logic [NUM_PORTS-1:0] rx_align_frame,
   input wire logic [NUM_PORTS-1:0] tx_multiframe,
   input wire logic [NUM_PORTS-1:0] one_second_tick,
   input wire logic [NUM_PORTS-1:0] tx_align_frame,
   input wire logic [NUM_PORTS-1:0] tx_clock_loss,
   input wire logic [NUM_PORTS-1:0] rx_crc4_multiframe,
   input wire logic [NUM_PORTS-1:0] prbs_detect,
   // rx_info_reg sources
   input wire logic [NUM_PORTS-1:0] jitter_limit_trip,
   input wire logic [NUM_PORTS-1:0] elastic_full,
   input wire logic [NUM_PORTS-1:0] elastic_empty,
   input wire logic [NUM_PORTS-1:0] crc4_resync_met,
   input wire logic [NUM_PORTS-1:0] frame_align_resync_met,
   input wire logic [NUM_PORTS-1:0] cas_mf_resync_met,
   // synchronizer state
   input wire logic [NUM_PORTS-1:0] frame_align_search_active,
   input wire logic [NUM_PORTS-1:0] cas_mf_search_active,
   input wire logic [NUM_PORTS-1:0] crc4_mf_search_active,
   input wire logic [NUM_PORTS-1:0] crc4_search_timeout,
   input wire logic [NUM_PORTS-1:0] crc4_synced,
   input wire logic [NUM_PORTS-1:0] crc4_mode_en,
   // interrupt
   output logic int_n_q
);
   // ========================================================================
   // helpers
   // ========================================================================
   function automatic logic [1:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [1:0] s;
      s = SLOT_NONE;
      if (a == ADDR_STATUS_ONE) s = SLOT_ONE;
      if (a == ADDR_STATUS_TWO) s = SLOT_TWO;
      if (a == ADDR_RX_INFO) s = SLOT_INFO;
      return s;
   endfunction : slot_of

   // bits that become set in the live latch this cycle
   function automatic logic [7:0] latch_set(input logic [7:0] lvl,
      input logic [7:0] prev, input logic [7:0] pulse,
      input logic [7:0] once, input logic [7:0] alarm);
      return (lvl & ~prev & once) | pulse | (lvl & alarm);
   endfunction : latch_set

   // bits that raise a pending interrupt this cycle
   function automatic logic [7:0] pend_set(input logic [7:0] lvl,
      input logic [7:0] prev, input logic [7:0] pulse,
      input logic [7:0] once, input logic [7:0] alarm);
      return (lvl & ~prev & once) | pulse | ((lvl ^ prev) & alarm);
   endfunction : pend_set

   // ========================================================================
   // state
   // ========================================================================
   logic [7:0] latch_q [NUM_PORTS][3];
   logic [7:0] latch_d [NUM_PORTS][3];
   logic [7:0] copy_q [NUM_PORTS][3];
   logic [7:0] copy_d [NUM_PORTS][3];
   logic [7:0] sel_q [NUM_PORTS][3];
   logic [7:0] sel_d [NUM_PORTS][3];
   logic [7:0] pend_q [NUM_PORTS][2];
   logic [7:0] pend_d [NUM_PORTS][2];
   logic [7:0] prev_q [NUM_PORTS][2];
   logic [7:0] prev_d [NUM_PORTS][2];
   logic [7:0] mask_q [NUM_PORTS][2];
   logic [7:0] mask_d [NUM_PORTS][2];
   logic [7:0] lvl_c [NUM_PORTS][2];
   logic [7:0] pulse_c [NUM_PORTS][3];
   logic [7:0] summary_c;
   logic [CNT_W-1:0] sync_cnt [NUM_PORTS];
   logic [7:0] sync_state_c [NUM_PORTS];
   logic [1:0] slot_c;
   logic [DATA_W-1:0] rdata_d;
   logic rvalid_d;
   logic int_n_d;

   // ========================================================================
   // source vectors
   // ========================================================================
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         lvl_c[p][0] = {rx_sig_all_ones[p], rx_distant_mf_alarm[p],
            rx_sig_all_zeros[p], 1'b0, rx_unframed_ones[p],
            rx_remote_alarm[p], rx_carrier_loss[p], rx_sync_loss[p]};
         pulse_c[p][0] = {3'b000, slip[p], 4'h0};
         lvl_c[p][1] = {5'h00, tx_clock_loss[p], 1'b0, prbs_detect[p]};
         pulse_c[p][1] = {rx_cas_multiframe[p], rx_align_frame[p],
            tx_multiframe[p], one_second_tick[p], tx_align_frame[p],
            1'b0, rx_crc4_multiframe[p], 1'b0};
         // info bits 7 and 6 unused
         pulse_c[p][2] = {2'b00, jitter_limit_trip[p],
            elastic_full[p], elastic_empty[p],
            crc4_resync_met[p],
            frame_align_resync_met[p],
            cas_mf_resync_met[p]} & INFO_USED;
         sync_state_c[p] = {sync_cnt[p][5:2], sync_cnt[p][0],
            frame_align_search_active[p], cas_mf_search_active[p],
            crc4_mf_search_active[p]};
      end
   end

   // ========================================================================
   // crc4 sync counters
   // ========================================================================
   for (genvar g = 0; g < NUM_PORTS; g++)
   begin : g_cnt
      crc4_sync_counter u_cnt (
         .core_clk(core_clk),
         .rst_n(rst_n),
         .search_timeout(crc4_search_timeout[g]),
         .crc4_synced(crc4_synced[g]),
         .crc4_mode_en(crc4_mode_en[g]),
         .count_q(sync_cnt[g])
      );
   end

   // ========================================================================
   // latched registers, pending interrupts and masks
   // ========================================================================
   always_comb
   begin
      logic [7:0] lset;
      logic [7:0] clr;
      logic hit;
      lset = RESET_BYTE;
      clr = RESET_BYTE;
      hit = 1'b0;
      slot_c = slot_of(reg_addr);
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         for (int r = 0; r < 3; r++)
         begin
            hit = (reg_port == 2'(p)) && (slot_c == 2'(r));
            if (r < 2)
            begin
               lset = latch_set(lvl_c[p][r], prev_q[p][r], pulse_c[p][r],
                  (r == 0) ? ONCE_MASK_ONE : ONCE_MASK_TWO,
                  (r == 0) ? ALARM_MASK_ONE : RESET_BYTE);
            end
            else
            begin
               lset = pulse_c[p][r];
            end
            // a read clears the bits the mask write captured as set
            clr = (hit && reg_rd) ? (sel_q[p][r] & copy_q[p][r]) : RESET_BYTE;
            latch_d[p][r] = (latch_q[p][r] & ~clr) | lset;
            copy_d[p][r] = copy_q[p][r];
            sel_d[p][r] = sel_q[p][r];
            if (hit && reg_wr)
            begin
               copy_d[p][r] = (copy_q[p][r] & ~reg_wdata)
                  | (latch_q[p][r] & reg_wdata);
               sel_d[p][r] = reg_wdata;
            end
            if (r < 2)
            begin
               clr = (hit && reg_rd) ? sel_q[p][r] : RESET_BYTE;
               pend_d[p][r] = (pend_q[p][r] & ~clr)
                  | pend_set(lvl_c[p][r], prev_q[p][r], pulse_c[p][r],
                     (r == 0) ? ONCE_MASK_ONE : ONCE_MASK_TWO,
                     (r == 0) ? ALARM_MASK_ONE : RESET_BYTE);
               prev_d[p][r] = lvl_c[p][r];
               mask_d[p][r] = mask_q[p][r];
               if (reg_wr && reg_port == 2'(p)
                  && reg_addr == ((r == 0) ? ADDR_MASK_ONE : ADDR_MASK_TWO))
               begin
                  mask_d[p][r] = reg_wdata;
               end
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (int p = 0; p < NUM_PORTS; p++)
         begin
            for (int r = 0; r < 3; r++)
            begin
               latch_q[p][r] <= RESET_BYTE;
               copy_q[p][r] <= RESET_BYTE;
               sel_q[p][r] <= RESET_BYTE;
            end
            for (int r = 0; r < 2; r++)
            begin
               pend_q[p][r] <= RESET_BYTE;
               prev_q[p][r] <= RESET_BYTE;
               mask_q[p][r] <= RESET_BYTE;
            end
         end
      end
      else
      begin
         latch_q <= latch_d;
         copy_q <= copy_d;
         sel_q <= sel_d;
         pend_q <= pend_d;
         prev_q <= prev_d;
         mask_q <= mask_d;
      end
   end

   // ========================================================================
   // summary, read data and interrupt pin
   // ========================================================================
   always_comb
   begin
      for (int p = 0; p < NUM_PORTS; p++)
      begin
         summary_c[2*p] = |(pend_q[p][0] & mask_q[p][0]);
         summary_c[2*p+1] = |(pend_q[p][1] & mask_q[p][1]);
      end
      int_n_d = ~|summary_c;
      rvalid_d = reg_rd;
      rdata_d = RESET_BYTE;
      if (reg_rd)
      begin
         if (slot_c != SLOT_NONE)
         begin
            rdata_d = copy_q[reg_port][slot_c];
         end
         else if (reg_addr == ADDR_SYNC_STATE)
         begin
            rdata_d = sync_state_c[reg_port];
         end
         else if (reg_addr >= ADDR_SUMMARY_LO && reg_addr <= ADDR_SUMMARY_HI)
         begin
            rdata_d = summary_c;
         end
         else if (reg_addr == ADDR_MASK_ONE)
         begin
            rdata_d = mask_q[reg_port][0];
         end
         else if (reg_addr == ADDR_MASK_TWO)
         begin
            rdata_d = mask_q[reg_port][1];
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         reg_rdata_q <= RESET_BYTE;
         reg_rvalid_q <= 1'b0;
         int_n_q <= 1'b1;
      end
      else
      begin
         reg_rdata_q <= rdata_d;
         reg_rvalid_q <= rvalid_d;
         int_n_q <= int_n_d;
      end
   end

   // ========================================================================
   // checks
   // ========================================================================
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd_one_p0;
      reg_rd && reg_port == 2'd0 && reg_addr == ADDR_STATUS_ONE;
   endsequence
   sequence s_rd_one_p2;
      reg_rd && reg_port == 2'd2 && reg_addr == ADDR_STATUS_ONE;
   endsequence
   sequence s_rd_two_p1;
      reg_rd && reg_port == 2'd1 && reg_addr == ADDR_STATUS_TWO;
   endsequence

   AST_READ_CLEARS: assert property (s_rd_one_p0 and (sel_q[0][0][4]
      && copy_q[0][0][4] && !slip[0]) |=> !latch_q[0][0][4])
      else $error("read did not clear latched slip");
   AST_ALARM_HELD: assert property (rx_sync_loss[2]
      |=> latch_q[2][0][0])
      else $error("present alarm not held");
   AST_MASK_WRITE: assert property (reg_wr && reg_port == 2'd0
      && reg_addr == ADDR_STATUS_ONE |=> copy_q[0][0] ==
      (($past(copy_q[0][0]) & ~$past(reg_wdata))
      | ($past(latch_q[0][0]) & $past(reg_wdata))))
      else $error("mask write copy wrong");
   AST_SYNC_LIVE: assert property (reg_rd && reg_port == 2'd0
      && reg_addr == ADDR_SYNC_STATE |=> reg_rvalid_q
      && reg_rdata_q == $past(sync_state_c[0]))
      else $error("sync state read wrong");
   AST_ALARM_EDGE: assert property (mask_q[2][0][0] && !reg_wr
      && $changed(rx_sync_loss[2]) |=> ##1 !int_n_q)
      else $error("alarm change did not interrupt");
   AST_ALARM_RELEASE: assert property (s_rd_one_p2 and (sel_q[2][0][0]
      && $stable(rx_sync_loss[2])) |=> !pend_q[2][0][0])
      else $error("alarm interrupt not released");
   AST_EVENT_RELEASE: assert property (s_rd_one_p0 and (sel_q[0][0][4]
      && !slip[0]) |=> !pend_q[0][0][4])
      else $error("event interrupt not released");
   AST_RECUR: assert property (one_second_tick[1] |=> pend_q[1][1][4])
      else $error("recurring event lost");
   AST_ONCE_ONLY: assert property (s_rd_two_p1 and (sel_q[1][1][0]
      && prbs_detect[1] && prev_q[1][1][0]) ##1 prbs_detect[1]
      |=> !pend_q[1][1][0])
      else $error("once-only event fired again");
   AST_SUMMARY: assert property (reg_rd && reg_addr == ADDR_SUMMARY_LO
      |=> reg_rdata_q[0] == $past(|(pend_q[0][0] & mask_q[0][0]))
      && reg_rdata_q[7] == $past(|(pend_q[3][1] & mask_q[3][1])))
      else $error("summary byte wrong");
   AST_INFO_SET: assert property (elastic_full[3] |=> latch_q[3][2][4])
      else $error("elastic full not latched");
   AST_INT_OR: assert property (1'b1
      |=> int_n_q == ($past(summary_c) == 8'h00))
      else $error("interrupt pin not the OR of sources");
endmodule : e1_status_interrupt_logic

// [test/e1_host_model.sv]
`timescale 1ns/1ps
// =========
// host processor on the register port
module e1_host_model
   import e1_status_pkg::*;
(
   // clock
   input wire logic core_clk,
   // register port
   output logic [1:0] reg_port,
   output logic [ADDR_W-1:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata_q,
   input wire logic reg_rvalid_q
);
   initial
   begin
      reg_port = 2'h0;
      reg_addr = 5'h1F;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end

   // one strobe cycle; address and data lines then show the inverse of the last value
   task automatic cyc(input logic [1:0] p, input logic [4:0] a,
      input logic w, input logic [7:0] d);
      @(posedge core_clk);
      #1;
      reg_port = p;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = w;
      reg_rd = !w;
      @(posedge core_clk);
      #1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask : cyc

   task automatic rd(input logic [1:0] p, input logic [4:0] a,
      output logic [7:0] d, output logic v);
      cyc(p, a, 1'b0, 8'h00);
      d = reg_rdata_q;
      v = reg_rvalid_q;
   endtask : rd

   // mask write, read, then write back the masked result
   task automatic poll(input logic [1:0] p, input logic [4:0] a,
      input logic [7:0] m, output logic [7:0] d, output logic v);
      cyc(p, a, 1'b1, m);
      rd(p, a, d, v);
      cyc(p, a, 1'b1, d & m);
   endtask : poll
endmodule : e1_host_model

// [test/e1_status_interrupt_logic_tb.sv]
`timescale 1ns/1ps
module e1_status_interrupt_logic_tb
   import e1_status_pkg::*;
;
   logic core_clk;
   logic rst_n;
   logic [1:0] reg_port;
   logic [ADDR_W-1:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata_q;
   logic reg_rvalid_q;
   logic int_n_q;
   // s1, s2 and inf indexed by register bit, one bit per port
   logic [3:0] s1 [8];
   logic [3:0] s2 [8];
   logic [3:0] inf [6];
   logic [3:0] sy [6];
   int errors = 0;
   int num_checks = 0;
   int cycles = 0;

   // =========
   // design and host
   e1_status_interrupt_logic i_dut (
      .core_clk, .rst_n, .reg_port, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata_q, .reg_rvalid_q, .int_n_q,
      .rx_sig_all_ones(s1[7]),
      .rx_distant_mf_alarm(s1[6]),
      .rx_sig_all_zeros(s1[5]),
      .slip(s1[4]),
      .rx_unframed_ones(s1[3]),
      .rx_remote_alarm(s1[2]),
      .rx_carrier_loss(s1[1]),
      .rx_sync_loss(s1[0]),
      .rx_cas_multiframe(s2[7]),
      .rx_align_frame(s2[6]),
      .tx_multiframe(s2[5]),
      .one_second_tick(s2[4]),
      .tx_align_frame(s2[3]),
      .tx_clock_loss(s2[2]),
      .rx_crc4_multiframe(s2[1]),
      .prbs_detect(s2[0]),
      .jitter_limit_trip(inf[5]),
      .elastic_full(inf[4]),
      .elastic_empty(inf[3]),
      .crc4_resync_met(inf[2]),
      .frame_align_resync_met(inf[1]),
      .cas_mf_resync_met(inf[0]),
      .frame_align_search_active(sy[0]),
      .cas_mf_search_active(sy[1]),
      .crc4_mf_search_active(sy[2]),
      .crc4_search_timeout(sy[3]),
      .crc4_synced(sy[4]),
      .crc4_mode_en(sy[5])
   );
   e1_host_model i_host (
      .core_clk, .reg_port, .reg_addr, .reg_wr, .reg_rd,
      .reg_wdata, .reg_rdata_q, .reg_rvalid_q
   );

   // =========
   // helpers
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic irq(input logic exp);
      check({7'h00, int_n_q}, {7'h00, exp});
   endtask : irq

   task automatic rchk(input logic [1:0] p, input logic [4:0] a,
      input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_host.rd(p, a, d, v);
      check(d, exp);
      check({7'h00, v}, 8'h01);
   endtask : rchk

   task automatic pchk(input logic [1:0] p, input logic [4:0] a,
      input logic [7:0] m, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      i_host.poll(p, a, m, d, v);
      check(d, exp);
      check({7'h00, v}, 8'h01);
   endtask : pchk

   task automatic set(input int g, input int b, input int p, input logic v);
      case (g)
         1: s1[b][p] = v;
         2: s2[b][p] = v;
         3: inf[b][p] = v;
         default: sy[b][p] = v;
      endcase
   endtask : set

   task automatic pulse(input int g, input int b, input int p);
      set(g, b, p, 1'b1);
      tick(1);
      set(g, b, p, 1'b0);
      tick(1);
   endtask : pulse

   // =========
   // scenarios
   task automatic t_reset;
      irq(1'b1);
      rchk(2'h0, ADDR_MASK_ONE, 8'h00);
      rchk(2'h3, ADDR_MASK_TWO, 8'h00);
      rchk(2'h1, 5'h1F, 8'h00);
      rchk(2'h2, ADDR_SUMMARY_LO, 8'h00);
   endtask : t_reset

   task automatic t_event;
      pulse(1, 4, 0);
      tick(2);
      irq(1'b1);
      rchk(2'h1, ADDR_SUMMARY_LO, 8'h00);
      pchk(2'h0, ADDR_STATUS_ONE, 8'h10, 8'h10);
      pchk(2'h0, ADDR_STATUS_ONE, 8'h10, 8'h00);
      i_host.cyc(2'h0, ADDR_MASK_ONE, 1'b1, 8'h10);
      pulse(1, 4, 0);
      tick(2);
      irq(1'b0);
      rchk(2'h2, 5'h0D, 8'h01);
      i_host.cyc(2'h0, ADDR_STATUS_ONE, 1'b1, 8'h00);
      rchk(2'h0, ADDR_STATUS_ONE, 8'h00);
      irq(1'b0);
      pchk(2'h0, ADDR_STATUS_ONE, 8'h10, 8'h10);
      irq(1'b1);
   endtask : t_event

   task automatic t_alarm;
      i_host.cyc(2'h2, ADDR_MASK_ONE, 1'b1, 8'h01);
      set(1, 0, 2, 1'b1);
      tick(3);
      irq(1'b0);
      rchk(2'h0, ADDR_SUMMARY_HI, 8'h10);
      pchk(2'h2, ADDR_STATUS_ONE, 8'h01, 8'h01);
      irq(1'b1);
      pchk(2'h2, ADDR_STATUS_ONE, 8'h01, 8'h01);
      set(1, 0, 2, 1'b0);
      tick(3);
      irq(1'b0);
      pchk(2'h2, ADDR_STATUS_ONE, 8'h01, 8'h01);
      pchk(2'h2, ADDR_STATUS_ONE, 8'h01, 8'h00);
      irq(1'b1);
   endtask : t_alarm

   task automatic t_once;
      i_host.cyc(2'h1, ADDR_MASK_TWO, 1'b1, 8'h11);
      set(2, 0, 1, 1'b1);
      tick(3);
      irq(1'b0);
      rchk(2'h3, ADDR_SUMMARY_LO, 8'h08);
      pchk(2'h1, ADDR_STATUS_TWO, 8'h01, 8'h01);
      tick(8);
      irq(1'b1);
      set(2, 0, 1, 1'b0);
      tick(3);
      irq(1'b1);
      set(2, 0, 1, 1'b1);
      tick(3);
      irq(1'b0);
      pchk(2'h1, ADDR_STATUS_TWO, 8'h01, 8'h01);
      repeat (2)
      begin
         pulse(2, 4, 1);
         tick(1);
         irq(1'b0);
         pchk(2'h1, ADDR_STATUS_TWO, 8'h10, 8'h10);
         irq(1'b1);
      end
   endtask : t_once

   task automatic info_bit(input int b);
      pulse(3, b, 3);
      pchk(2'h3, ADDR_RX_INFO, 8'hFF, 8'h01 << b);
      irq(1'b1);
   endtask : info_bit

   task automatic t_info;
      info_bit(0);
      info_bit(1);
      info_bit(2);
      info_bit(3);
      info_bit(4);
      info_bit(5);
   endtask : t_info

   task automatic t_sync;
      set(4, 5, 0, 1'b1);
      set(4, 0, 0, 1'b1);
      set(4, 2, 0, 1'b1);
      tick(1);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h05);
      repeat (3) pulse(4, 3, 0);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h0D);
      repeat (2) pulse(4, 3, 0);
      i_host.cyc(2'h0, ADDR_SYNC_STATE, 1'b1, 8'hFF);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h1D);
      repeat (59) pulse(4, 3, 0);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h05);
      repeat (4) pulse(4, 3, 0);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h15);
      set(4, 4, 0, 1'b1);
      tick(2);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h05);
      set(4, 4, 0, 1'b0);
      pulse(4, 3, 0);
      set(4, 5, 0, 1'b0);
      set(4, 0, 0, 1'b0);
      set(4, 1, 0, 1'b1);
      set(4, 2, 0, 1'b0);
      tick(2);
      rchk(2'h0, ADDR_SYNC_STATE, 8'h02);
   endtask : t_sync

   task automatic print_verdict;
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict

   // =========
   // clock, reset, sequence and hang limit
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   initial
   begin
      rst_n = 1'b0;
      foreach (s1[i]) s1[i] = 4'h0;
      foreach (s2[i]) s2[i] = 4'h0;
      foreach (inf[i]) inf[i] = 4'h0;
      foreach (sy[i]) sy[i] = 4'h0;
      tick(16);
      irq(1'b1);
      check({7'h00, reg_rvalid_q}, 8'h00);
      rst_n = 1'b1;
      t_reset();
      t_event();
      t_alarm();
      t_once();
      t_info();
      t_sync();
      print_verdict();
   end

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         errors++;
         print_verdict();
      end
   end
endmodule : e1_status_interrupt_logic_tb
